// File: timer_cmp_pkg.sv
/*
 * Constants for the timer compare, force and control block: register
 * indices, field positions, reset values and timing counts.
 * Assumes a 32-bit APB bus where byte address = 4 * register index.
 */
package timer_cmp_pkg;

   // Register indices (byte address is four times the index)
   localparam logic [5:0] IDX_MODE_SELECT = 6'h00;
   localparam logic [5:0] IDX_COMPARE_FORCE = 6'h01;
   localparam logic [5:0] IDX_OVR_MASK = 6'h02;
   localparam logic [5:0] IDX_OVR_DATA = 6'h03;
   localparam logic [5:0] IDX_COUNTER_HIGH = 6'h04;
   localparam logic [5:0] IDX_COUNTER_LOW = 6'h05;
   localparam logic [5:0] IDX_SYS_CTRL_ONE = 6'h06;
   localparam logic [5:0] IDX_OVF_TOGGLE = 6'h07;
   localparam logic [5:0] IDX_OUT_CTRL_ONE = 6'h08;
   localparam logic [5:0] IDX_OUT_CTRL_TWO = 6'h09;
   localparam logic [5:0] IDX_CHAN_FLAGS = 6'h0e;
   localparam logic [5:0] IDX_OVF_FLAGS = 6'h0f;
   localparam logic [5:0] IDX_CHAN_BASE = 6'h10;
   localparam logic [5:0] IDX_CHAN_LAST = 6'h1f;
   localparam logic [5:0] IDX_ACC_HIGH = 6'h22;
   localparam logic [5:0] IDX_ACC_LOW = 6'h23;
   localparam logic [5:0] IDX_COUNTER_WORD = 6'h30;

   // Fields of system control one
   localparam int BIT_TIMER_ENABLE = 7;
   localparam int BIT_STOP_IN_WAIT = 6;
   localparam int BIT_STOP_IN_FREEZE = 5;
   localparam int BIT_FAST_FLAG_CLEAR = 4;
   localparam logic [7:0] SYS_CTRL_WMASK = 8'hf0;

   // Overflow flag position in its register
   localparam int BIT_OVF_FLAG = 7;

   // Channels 7..2 live in bits 7..2 of the byte registers
   localparam int CHAN_LO = 2;
   localparam int CHAN_HI = 7;
   localparam logic [7:0] CHAN_MASK = 8'hfc;

   // Reset values and counter maximum
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [15:0] COUNTER_MAX = 16'hffff;

   // Prescaler: divide-by-64 tick for the accumulator
   localparam int PRESC_DIV = 64;
   localparam logic [5:0] PRESC_LAST = 6'(PRESC_DIV - 1);

   // Compare output actions {mode, level}
   localparam logic [1:0] ACT_OFF = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;

endpackage : timer_cmp_pkg

// File: timer_compare_force_and_control.sv
/*
 * Timer compare, force and control block: 16-bit up counter, compare
 * channels 7..2 with force, channel-7 override, toggle on overflow,
 * enable/wait/freeze controls and fast flag clearing, behind APB.
 * Assumes countTick is the prescaled counter enable from the prescaler
 * select logic and that capture edges arrive already detected.
 */
`timescale 1ns/1ns
module timer_compare_force_and_control (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Chip mode and timing inputs
   input wire logic countTick,
   input wire logic testMode,
   input wire logic waitMode,
   input wire logic freezeMode,
   // Capture events and accumulator count from neighbouring logic
   input wire logic [7:2] captureEvent,
   input wire logic [15:0] accumulatorCount,
   // Channel pins
   output logic [7:2] chanOut,
   output logic [7:2] chanOe,
   // Status toward interrupt and accumulator logic
   output logic [7:2] chanFlag,
   output logic overflowFlag,
   output logic accDiv64Tick,
   output logic accRun,
   output logic accFlagClear,
   output logic wakeAllowed
);

   logic [7:0] modeSel_r;
   logic [7:0] ovrMask_r;
   logic [7:0] ovrData_r;
   logic [7:0] sysCtrl_r;
   logic [7:0] ovfToggle_r;
   logic [7:0] outCtrl1_r;
   logic [7:0] outCtrl2_r;
   logic [15:0] counter_r;
   logic [15:0] chanReg_r [7:2];
   logic [7:2] chanFlag_r;
   logic ovfFlag_r;
   logic [5:0] presc_r;
   logic div64_r;
   logic [7:2] pin_r;
   logic [31:0] rdData_r;

   logic [5:0] idx;
   logic access;
   logic wrAcc;
   logic rdAcc;
   logic setupRd;
   logic fastClear;
   logic timerActive;
   logic counterRun;
   logic cntStep;
   logic [15:0] cntNext;
   logic overflow;
   logic [7:2] match;
   logic [7:2] force_;
   logic [7:2] isCmp;
   logic [31:0] rdMux;
   logic [7:2] chanFastClr;

   function automatic logic isMapped(input logic [5:0] i);
      isMapped = (i <= timer_cmp_pkg::IDX_OUT_CTRL_TWO) ||
         i == timer_cmp_pkg::IDX_CHAN_FLAGS ||
         i == timer_cmp_pkg::IDX_OVF_FLAGS ||
         (i >= timer_cmp_pkg::IDX_CHAN_BASE &&
          i <= timer_cmp_pkg::IDX_CHAN_LAST) ||
         i == timer_cmp_pkg::IDX_ACC_HIGH ||
         i == timer_cmp_pkg::IDX_ACC_LOW ||
         i == timer_cmp_pkg::IDX_COUNTER_WORD;
   endfunction : isMapped

   // Channel of a compare register byte index; 0 when none
   function automatic int chanOf(input logic [5:0] i);
      chanOf = (i >= timer_cmp_pkg::IDX_CHAN_BASE &&
                i <= timer_cmp_pkg::IDX_CHAN_LAST) ?
               int'(i[3:1]) : 0;
   endfunction : chanOf

   // Output action code of channel c
   function automatic logic [1:0] actionOf(input int c);
      // Channels 3..2 sit in the upper nibble of the second byte
      actionOf = (c >= 4) ? outCtrl1_r[2*(c-4) +: 2] :
                            outCtrl2_r[2*(c-2) + 4 +: 2];
   endfunction : actionOf

   // Pin level after applying an action
   function automatic logic applyAction(input logic [1:0] act,
                                        input logic cur);
      case (act)
         timer_cmp_pkg::ACT_TOGGLE: applyAction = ~cur;
         timer_cmp_pkg::ACT_CLEAR: applyAction = 1'b0;
         timer_cmp_pkg::ACT_SET: applyAction = 1'b1;
         default: applyAction = cur;
      endcase
   endfunction : applyAction

   assign idx = paddr[7:2];
   assign access = psel && penable;
   assign wrAcc = access && pwrite;
   assign rdAcc = access && !pwrite;
   assign setupRd = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = access && !isMapped(idx);
   assign prdata = rdData_r;

   assign fastClear = sysCtrl_r[timer_cmp_pkg::BIT_FAST_FLAG_CLEAR];
   assign timerActive = sysCtrl_r[timer_cmp_pkg::BIT_TIMER_ENABLE] &&
      !(waitMode && sysCtrl_r[timer_cmp_pkg::BIT_STOP_IN_WAIT]);
   assign counterRun = timerActive &&
      !(freezeMode && sysCtrl_r[timer_cmp_pkg::BIT_STOP_IN_FREEZE]);
   // Freeze leaves the accumulator running; only enable and wait stop it
   assign accRun = timerActive;
   assign wakeAllowed = !sysCtrl_r[timer_cmp_pkg::BIT_STOP_IN_WAIT];
   assign cntStep = counterRun && countTick;
   assign cntNext = counter_r + 16'h0001;
   assign overflow = cntStep && counter_r == timer_cmp_pkg::COUNTER_MAX;
   assign isCmp = modeSel_r[7:2];

   // Match fires once, on the step that brings the counter onto the value
   always_comb begin
      for (int c = timer_cmp_pkg::CHAN_LO; c <= timer_cmp_pkg::CHAN_HI;
           c++) begin
         match[c] = cntStep && isCmp[c] && cntNext == chanReg_r[c];
         force_[c] = wrAcc && idx == timer_cmp_pkg::IDX_COMPARE_FORCE &&
            pwdata[c];
      end
   end

   // Fast clear of channel flags from channel register accesses
   always_comb begin
      for (int c = timer_cmp_pkg::CHAN_LO; c <= timer_cmp_pkg::CHAN_HI;
           c++) begin
         chanFastClr[c] = fastClear && chanOf(idx) == c &&
            ((rdAcc && !isCmp[c]) || (wrAcc && isCmp[c]));
      end
   end

   always_comb begin
      rdMux = 32'h0000_0000;
      case (idx)
         timer_cmp_pkg::IDX_MODE_SELECT:
            rdMux[7:0] = modeSel_r & timer_cmp_pkg::CHAN_MASK;
         timer_cmp_pkg::IDX_COMPARE_FORCE:
            rdMux[7:0] = 8'h00;
         timer_cmp_pkg::IDX_OVR_MASK: rdMux[7:0] = ovrMask_r;
         timer_cmp_pkg::IDX_OVR_DATA: rdMux[7:0] = ovrData_r;
         timer_cmp_pkg::IDX_COUNTER_HIGH: rdMux[7:0] = counter_r[15:8];
         timer_cmp_pkg::IDX_COUNTER_LOW: rdMux[7:0] = counter_r[7:0];
         timer_cmp_pkg::IDX_COUNTER_WORD:
            rdMux[15:0] = counter_r;
         timer_cmp_pkg::IDX_SYS_CTRL_ONE: rdMux[7:0] = sysCtrl_r;
         timer_cmp_pkg::IDX_OVF_TOGGLE: rdMux[7:0] = ovfToggle_r;
         timer_cmp_pkg::IDX_OUT_CTRL_ONE: rdMux[7:0] = outCtrl1_r;
         timer_cmp_pkg::IDX_OUT_CTRL_TWO: rdMux[7:0] = outCtrl2_r;
         timer_cmp_pkg::IDX_CHAN_FLAGS: rdMux[7:2] = chanFlag_r;
         timer_cmp_pkg::IDX_OVF_FLAGS:
            rdMux[timer_cmp_pkg::BIT_OVF_FLAG] = ovfFlag_r;
         timer_cmp_pkg::IDX_ACC_HIGH: rdMux[7:0] = accumulatorCount[15:8];
         timer_cmp_pkg::IDX_ACC_LOW: rdMux[7:0] = accumulatorCount[7:0];
         default: begin
            if (chanOf(idx) >= timer_cmp_pkg::CHAN_LO) begin
               rdMux[7:0] = idx[0] ? chanReg_r[chanOf(idx)][7:0] :
                                     chanReg_r[chanOf(idx)][15:8];
            end
         end
      endcase
   end

   // Read data captured in the setup phase, held through the access
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdData_r <= 32'h0000_0000;
      end else if (setupRd) begin
         rdData_r <= rdMux;
      end
   end

   // Software control registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         modeSel_r <= timer_cmp_pkg::RST_BYTE;
         ovrMask_r <= timer_cmp_pkg::RST_BYTE;
         ovrData_r <= timer_cmp_pkg::RST_BYTE;
         sysCtrl_r <= timer_cmp_pkg::RST_BYTE;
         ovfToggle_r <= timer_cmp_pkg::RST_BYTE;
         outCtrl1_r <= timer_cmp_pkg::RST_BYTE;
         outCtrl2_r <= timer_cmp_pkg::RST_BYTE;
      end else if (wrAcc) begin
         case (idx)
            timer_cmp_pkg::IDX_MODE_SELECT:
               modeSel_r <= pwdata[7:0] & timer_cmp_pkg::CHAN_MASK;
            timer_cmp_pkg::IDX_OVR_MASK:
               ovrMask_r <= pwdata[7:0] & timer_cmp_pkg::CHAN_MASK;
            timer_cmp_pkg::IDX_OVR_DATA:
               ovrData_r <= pwdata[7:0] & timer_cmp_pkg::CHAN_MASK;
            timer_cmp_pkg::IDX_SYS_CTRL_ONE:
               sysCtrl_r <= pwdata[7:0] & timer_cmp_pkg::SYS_CTRL_WMASK;
            timer_cmp_pkg::IDX_OVF_TOGGLE:
               ovfToggle_r <= pwdata[7:0] & timer_cmp_pkg::CHAN_MASK;
            timer_cmp_pkg::IDX_OUT_CTRL_ONE: outCtrl1_r <= pwdata[7:0];
            timer_cmp_pkg::IDX_OUT_CTRL_TWO:
               outCtrl2_r <= {pwdata[7:4], 4'h0};
            default: begin
            end
         endcase
      end
   end

   // Main counter; a test-mode write beats a step in the same cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         counter_r <= timer_cmp_pkg::RST_WORD;
      end else if (wrAcc && testMode &&
                   idx == timer_cmp_pkg::IDX_COUNTER_HIGH) begin
         counter_r <= {pwdata[7:0], counter_r[7:0]};
      end else if (wrAcc && testMode &&
                   idx == timer_cmp_pkg::IDX_COUNTER_LOW) begin
         counter_r <= {counter_r[15:8], pwdata[7:0]};
      end else if (wrAcc && testMode &&
                   idx == timer_cmp_pkg::IDX_COUNTER_WORD) begin
         counter_r <= pwdata[15:0];
      end else if (cntStep) begin
         counter_r <= cntNext;
      end
   end

   // Prescaler is never realigned by a counter write
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         presc_r <= 6'h00;
         div64_r <= 1'b0;
      end else if (timerActive) begin
         presc_r <= presc_r + 6'h01;
         div64_r <= presc_r == timer_cmp_pkg::PRESC_LAST;
      end else begin
         div64_r <= 1'b0;
      end
   end
   assign accDiv64Tick = div64_r;

   // Channel registers: software compare value or captured count
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int c = timer_cmp_pkg::CHAN_LO; c <= timer_cmp_pkg::CHAN_HI;
              c++) begin
            chanReg_r[c] <= timer_cmp_pkg::RST_WORD;
         end
      end else begin
         for (int c = timer_cmp_pkg::CHAN_LO; c <= timer_cmp_pkg::CHAN_HI;
              c++) begin
            if (captureEvent[c] && !isCmp[c] && timerActive) begin
               chanReg_r[c] <= counter_r;
            end else if (wrAcc && chanOf(idx) == c) begin
               if (idx[0]) begin
                  chanReg_r[c][7:0] <= pwdata[7:0];
               end else begin
                  chanReg_r[c][15:8] <= pwdata[7:0];
               end
            end
         end
      end
   end

   // Channel flags: write one to clear; a new event beats the clear
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         chanFlag_r <= 6'h00;
      end else begin
         for (int c = timer_cmp_pkg::CHAN_LO; c <= timer_cmp_pkg::CHAN_HI;
              c++) begin
            if ((match[c] && !force_[c]) ||
                (captureEvent[c] && !isCmp[c] && timerActive)) begin
               chanFlag_r[c] <= 1'b1;
            end else if ((wrAcc && idx == timer_cmp_pkg::IDX_CHAN_FLAGS &&
                          pwdata[c]) || chanFastClr[c]) begin
               chanFlag_r[c] <= 1'b0;
            end
         end
      end
   end
   assign chanFlag = chanFlag_r;

   // Overflow flag
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ovfFlag_r <= 1'b0;
      end else if (overflow) begin
         ovfFlag_r <= 1'b1;
      end else if ((wrAcc && idx == timer_cmp_pkg::IDX_OVF_FLAGS &&
                    pwdata[timer_cmp_pkg::BIT_OVF_FLAG]) ||
                   (access && fastClear &&
                    (idx == timer_cmp_pkg::IDX_COUNTER_HIGH ||
                     idx == timer_cmp_pkg::IDX_COUNTER_LOW ||
                     idx == timer_cmp_pkg::IDX_COUNTER_WORD))) begin
         ovfFlag_r <= 1'b0;
      end
   end
   assign overflowFlag = ovfFlag_r;

   // Accumulator flags live next door; this pulse clears both
   assign accFlagClear = access && fastClear &&
      (idx == timer_cmp_pkg::IDX_ACC_HIGH ||
       idx == timer_cmp_pkg::IDX_ACC_LOW);

   // Pin levels: override, then overflow toggle, then force or match
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pin_r <= 6'h00;
      end else begin
         for (int c = timer_cmp_pkg::CHAN_LO; c <= timer_cmp_pkg::CHAN_HI;
              c++) begin
            if (!isCmp[c]) begin
               pin_r[c] <= pin_r[c];
            end else if (match[7] && ovrMask_r[c]) begin
               pin_r[c] <= ovrData_r[c];
            end else if (overflow && ovfToggle_r[c]) begin
               pin_r[c] <= ~pin_r[c];
            end else if (force_[c] || match[c]) begin
               pin_r[c] <= applyAction(actionOf(c), pin_r[c]);
            end
         end
      end
   end
   assign chanOut = pin_r;

   // Pin drives when in compare mode with an action or a mask bit set
   always_comb begin
      for (int c = timer_cmp_pkg::CHAN_LO; c <= timer_cmp_pkg::CHAN_HI;
           c++) begin
         chanOe[c] = isCmp[c] &&
            (actionOf(c) != timer_cmp_pkg::ACT_OFF || ovrMask_r[c]);
      end
   end

endmodule : timer_compare_force_and_control

// File: timer_cmp_asserts.sv
/* Port checker for the timer compare block; rebuilds the control
   registers from APB writes. Assumes a bind to the block's top. */
`timescale 1ns/1ns
module timer_cmp_asserts (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // Mode and events
   input wire logic waitMode,
   input wire logic [7:2] captureEvent,
   // Watched outputs
   input wire logic [7:2] chanOut,
   input wire logic [7:2] chanOe,
   input wire logic [7:2] chanFlag,
   input wire logic overflowFlag,
   input wire logic accDiv64Tick,
   input wire logic accRun,
   input wire logic accFlagClear,
   input wire logic wakeAllowed
);
   logic [7:2] modeR, maskR, frcR, oeExp;
   logic [7:0] ctrlR;
   logic [11:0] actR;
   logic [5:0] idx;
   logic acc, wrAcc;
   assign idx = paddr[7:2];
   assign acc = psel && penable;
   assign wrAcc = acc && pwrite;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         modeR <= 6'h0;
         maskR <= 6'h0;
         ctrlR <= 8'h0;
         actR <= 12'h0;
         frcR <= 6'h0;
      end else begin
         if (wrAcc && idx == 6'h00) modeR <= pwdata[7:2];
         if (wrAcc && idx == 6'h02) maskR <= pwdata[7:2];
         if (wrAcc && idx == 6'h06) ctrlR <= pwdata[7:0] & 8'hf0;
         if (wrAcc && idx == 6'h08) actR[11:4] <= pwdata[7:0];
         if (wrAcc && idx == 6'h09) actR[3:0] <= pwdata[7:4];
         // Capture may set a flag legally, so skip those cycles
         frcR <= (wrAcc && idx == 6'h01 && captureEvent == 6'h0) ?
            pwdata[7:2] : 6'h0;
      end
   end
   always_comb begin
      for (int c = 2; c < 8; c++) begin
         oeExp[c] = modeR[c] && (actR[2*(c-2) +: 2] != 2'h0 || maskR[c]);
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   AST_FORCE_RD:
      assert property (acc && !pwrite && idx == 6'h01 |-> prdata == 32'h0)
      else $error("force register read not zero");
   AST_FORCE_NOFLAG:
      assert property (frcR != 6'h0 |->
         (chanFlag & ~$past(chanFlag) & frcR) == 6'h0)
      else $error("forced action set a channel flag");
   AST_PIN_OE:
      assert property (chanOe == oeExp)
      else $error("pin drive enable wrong");
   AST_RUN:
      assert property (accRun == (ctrlR[7] && !(waitMode && ctrlR[6])))
      else $error("accumulator run level wrong");
   AST_WAKE:
      assert property (wakeAllowed == !ctrlR[6])
      else $error("wake permission wrong");
   AST_TICK_OFF:
      assert property (!accRun && $past(accRun) == 1'b0 |-> !accDiv64Tick)
      else $error("divide tick while timer inactive");
   AST_PIN_HOLD:
      assert property (((chanOut ^ $past(chanOut)) & ~$past(modeR)) == 6'h0)
      else $error("capture channel pin moved");
   AST_ACC_CLR:
      assert property (acc && ctrlR[4] && (idx == 6'h22 || idx == 6'h23)
         |-> accFlagClear)
      else $error("accumulator flags not cleared");
   AST_OVF_CLR:
      assert property (acc && ctrlR[4] && !ctrlR[7] &&
         (idx == 6'h04 || idx == 6'h05 || idx == 6'h30) |=> !overflowFlag)
      else $error("overflow flag not cleared");
endmodule : timer_cmp_asserts

// File: apb_cpu_model.sv
/* APB master standing in for CPU software, one transfer per call.
   Assumes the slave answers through pready; the wait is bounded. */
`timescale 1ns/1ns
module apb_cpu_model (
   // Clock
   input wire logic sys_clk,
   // APB
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   logic hung = 1'b0;
   logic errSeen = 1'b0;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
   end
   // Counter word goes in one transfer so both bytes agree
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      q = prdata;
      errSeen = pslverr;
      hung = (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines must not keep their last value
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
endmodule : apb_cpu_model

// File: tb.sv
/* Self-checking bench for the timer compare block, one task per test.
   Assumes the CPU model and checker files are compiled first. */
`timescale 1ns/1ns
module tb;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic countTick = 1'b0;
   logic testMode = 1'b0;
   logic waitMode = 1'b0;
   logic freezeMode = 1'b0;
   logic [7:2] captureEvent = 6'h0;
   logic [15:0] accumulatorCount = 16'h1234;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:2] chanOut, chanOe, chanFlag;
   logic overflowFlag, accDiv64Tick, accRun, accFlagClear, wakeAllowed;
   int mismatches = 0;
   int testsRun = 0;

   always #2 sys_clk = ~sys_clk;

   timer_compare_force_and_control timer_compare_force_and_control_i (
      .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .countTick(countTick),
      .testMode(testMode), .waitMode(waitMode), .freezeMode(freezeMode),
      .captureEvent(captureEvent), .accumulatorCount(accumulatorCount),
      .chanOut(chanOut), .chanOe(chanOe), .chanFlag(chanFlag),
      .overflowFlag(overflowFlag), .accDiv64Tick(accDiv64Tick),
      .accRun(accRun), .accFlagClear(accFlagClear),
      .wakeAllowed(wakeAllowed));

   apb_cpu_model cpu_model_i (
      .sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   task wrap_up;
      $display("comparisons %0d mismatches %0d", testsRun, mismatches);
      if (mismatches == 0 && testsRun > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up

   task check(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask : check

   always @(posedge sys_clk) begin
      if (cpu_model_i.hung === 1'b1) begin
         mismatches++;
         wrap_up();
      end
   end

   task wr(input logic [5:0] i, input logic [31:0] d);
      logic [31:0] q;
      cpu_model_i.xfer(1'b1, {i, 2'h0}, d, q);
   endtask : wr

   task rd(input logic [5:0] i, output logic [31:0] q);
      cpu_model_i.xfer(1'b0, {i, 2'h0}, 32'h0, q);
   endtask : rd

   task ticks(input int k);
      repeat (k) begin
         countTick <= 1'b1;
         @(posedge sys_clk);
         countTick <= 1'b0;
         @(posedge sys_clk);
      end
   endtask : ticks

   task t_regs;
      logic [31:0] q;
      rd(6'h02, q);
      check(q, 32'h0);
      wr(6'h02, 32'hfc);
      rd(6'h02, q);
      check(q, 32'hfc);
      wr(6'h02, 32'h0);
      wr(6'h01, 32'hfc);
      rd(6'h01, q);
      check(q, 32'h0);
      check(chanOut, 6'h0);
      wr(6'h06, 32'h10);
      rd(6'h23, q);
      check(q, 32'h34);
      wr(6'h06, 32'h0);
      rd(6'h3f, q);
      check(cpu_model_i.errSeen, 1'b1);
      check(q, 32'h0);
      $display("test regs done");
   endtask : t_regs

   task t_count;
      logic [31:0] q;
      wr(6'h06, 32'h80);
      ticks(5);
      rd(6'h30, q);
      check(q, 32'h5);
      wr(6'h06, 32'h0);
      ticks(3);
      rd(6'h30, q);
      check(q, 32'h5);
      wr(6'h30, 32'h1234);
      rd(6'h30, q);
      check(q, 32'h5);
      testMode <= 1'b1;
      wr(6'h30, 32'hfffe);
      testMode <= 1'b0;
      wr(6'h06, 32'h80);
      ticks(2);
      check(overflowFlag, 1'b1);
      wr(6'h06, 32'h10);
      rd(6'h05, q);
      @(negedge sys_clk);
      check(overflowFlag, 1'b0);
      check(q, 32'h0);
      $display("test count done");
   endtask : t_count

   task t_force;
      logic [7:2] pin;
      logic [1:0] code;
      pin = 6'h0;
      wr(6'h00, 32'hfc);
      for (int k = 3; k >= 0; k--) begin
         code = 2'(k);
         wr(6'h08, {24'h0, {4{code}}});
         wr(6'h09, {24'h0, {2{code}}, 4'h0});
         wr(6'h01, 32'hfc);
         pin = (code == 2'h1) ? ~pin : (code == 2'h0) ? pin : {6{code[0]}};
         @(negedge sys_clk);
         check(chanOut, pin);
         check(chanOe, (code != 2'h0) ? 32'h3f : 32'h0);
         check(chanFlag, 6'h0);
      end
      $display("test force done");
   endtask : t_force

   task t_ch7;
      wr(6'h06, 32'h0);
      testMode <= 1'b1;
      wr(6'h30, 32'h0);
      testMode <= 1'b0;
      wr(6'h1f, 32'h3);
      wr(6'h15, 32'h3);
      wr(6'h08, 32'haa);
      wr(6'h09, 32'ha0);
      wr(6'h02, 32'h0c);
      wr(6'h03, 32'h04);
      wr(6'h06, 32'h80);
      ticks(3);
      check(chanOut, 6'h1d);
      check(chanFlag, 6'h21);
      wr(6'h06, 32'h0);
      testMode <= 1'b1;
      wr(6'h30, 32'hffff);
      testMode <= 1'b0;
      wr(6'h08, 32'h80);
      wr(6'h09, 32'h0);
      wr(6'h07, 32'h30);
      wr(6'h06, 32'h80);
      ticks(1);
      check(chanOut, 6'h11);
      check(chanFlag, 6'h3f);
      wr(6'h06, 32'h10);
      wr(6'h15, 32'h3);
      @(negedge sys_clk);
      check(chanFlag, 6'h3e);
      wr(6'h06, 32'h80);
      wr(6'h0e, 32'hfc);
      countTick <= 1'b1;
      wr(6'h01, 32'h04);
      countTick <= 1'b0;
      @(negedge sys_clk);
      check(chanFlag, 6'h20);
      $display("test override done");
   endtask : t_ch7

   task t_wait;
      logic [31:0] p, q;
      int n;
      wr(6'h06, 32'hc0);
      waitMode <= 1'b1;
      @(negedge sys_clk);
      check(accRun, 1'b0);
      check(wakeAllowed, 1'b0);
      rd(6'h30, p);
      ticks(4);
      rd(6'h30, q);
      check(q, p);
      n = 0;
      repeat (140) @(posedge sys_clk) n += int'(accDiv64Tick === 1'b1);
      check(n, 0);
      waitMode <= 1'b0;
      n = 0;
      repeat (140) @(posedge sys_clk) n += int'(accDiv64Tick === 1'b1);
      check(n >= 2 && n <= 3, 1'b1);
      wr(6'h06, 32'ha0);
      freezeMode <= 1'b1;
      ticks(3);
      rd(6'h30, q);
      check(q, p);
      check(accRun, 1'b1);
      freezeMode <= 1'b0;
      ticks(2);
      rd(6'h30, q);
      check(q, p + 32'h2);
      wr(6'h00, 32'hbc);
      wr(6'h06, 32'h90);
      captureEvent <= 6'h10;
      @(posedge sys_clk);
      captureEvent <= 6'h00;
      @(negedge sys_clk);
      check(chanFlag, 6'h30);
      rd(6'h1d, q);
      check(q, p + 32'h2);
      @(negedge sys_clk);
      check(chanFlag, 6'h20);
      $display("test wait done");
   endtask : t_wait

   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      t_regs();
      t_count();
      t_force();
      t_ch7();
      t_wait();
      wrap_up();
   end
endmodule : tb

bind timer_compare_force_and_control timer_cmp_asserts timer_cmp_asserts_i (
   .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .waitMode(waitMode), .captureEvent(captureEvent), .chanOut(chanOut),
   .chanOe(chanOe), .chanFlag(chanFlag), .overflowFlag(overflowFlag),
   .accDiv64Tick(accDiv64Tick), .accRun(accRun),
   .accFlagClear(accFlagClear), .wakeAllowed(wakeAllowed));
